// >>> src/dic_regs.svh
// Register offsets, field positions, reset values and timing constants
`ifndef DIC_REGS_SVH
`define DIC_REGS_SVH
`define OFF_CTRL 12'h000
`define OFF_COUNT 12'h004
`define OFF_SAMPLE 12'h008
`define OFF_GATE 12'h00C
`define OFF_FREQ_CNT 12'h010
`define OFF_FREQ_MS 12'h014
`define OFF_STATUS 12'h018
`define OFF_QUAD 12'h01C
`define OFF_FIXED 12'h020
`define OFF_SYNTH 12'h024
`define CTRL_CLR 0
`define CTRL_EDGE_P 1
`define CTRL_EDGE_L 2
`define CTRL_INV 3
`define CTRL_TEST 4
`define CTRL_ROT 5
`define CTRL_DEB_LO 8
`define CTRL_DEB_HI 15
`define GATE_RST 16'h00C8
`define LFSR_SEED 16'hACE1
`define CLK_NS 10
`define HALF_MS_NS 500000
`define SLOW_READ_MS 500
`define CODE_TICK 32'h0000_0001
`define CODE_RAND 32'h0000_0002
`define CODE_INC 32'h0000_0003
`define CODE_INC_SLOW 32'h0000_0004
`endif

// >>> src/dic_pkg.sv
// Types shared by the digital input counter
package dic_pkg;
  typedef enum logic [0:0] {
    FQ_IDLE = 1'b0,
    FQ_SECOND = 1'b1
  } freq_state_t;
endpackage

// >>> src/input_debounce.sv
// Input synchroniser and debounce filter for one sensor line
`timescale 1ns/1ps
module input_debounce #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic raw,
  input wire logic half_ms,
  input wire logic [W-1:0] setting,
  output logic state,
  output logic changed
);
  if (W < 1 || W > 16) begin : g_chk
    $error("input_debounce: W out of range");
  end

  typedef struct packed {
    logic s1;
    logic s2;
    logic acc;
    logic chg;
    logic [1:0] warm;
    logic [W-1:0] cnt;
  } deb_t;

  deb_t q;
  deb_t n;

  always_comb begin
    n = q;
    n.s1 = raw;
    n.s2 = q.s1;
    n.chg = 1'b0;
    if (!(&q.warm)) begin
      // Take the pin's idle level after reset silently, so a pulled-up line gives no false edge
      n.warm = q.warm + 2'h1;
      n.acc = q.s2;
      n.cnt = '0;
    end else if (q.s2 == q.acc) begin
      n.cnt = '0;
    end else if (setting == '0) begin
      n.acc = q.s2;
      n.chg = 1'b1;
    end else if (half_ms) begin
      // Accept on the tick after N whole ticks of stability
      if (q.cnt == setting) begin
        n.acc = q.s2;
        n.chg = 1'b1;
        n.cnt = '0;
      end else begin
        n.cnt = W'(q.cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign state = q.acc;
  assign changed = q.chg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_no_filter_pass: assert property ((&q.warm && setting == '0 && q.s2 != q.acc)
    |=> changed)
    else $error("unfiltered change not passed");
  chk_filter_tick: assert property ((changed && setting != '0) |-> $past(half_ms))
    else $error("filtered change without a half-ms tick");
  chk_timer_restart: assert property ((q.s2 == q.acc) |=> (q.cnt == '0))
    else $error("stability timer not restarted");
  chk_sync_depth: assert property ($changed(state) |-> $past(raw, 3) == state)
    else $error("state changed without synchronised input");
endmodule // input_debounce

// >>> src/digital_input_counter.sv
// Digital input block: pulse counter, debounce, frequency, quadrature, level, test source
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "dic_regs.svh"
module digital_input_counter #(
  parameter int HALF_MS_CYCLES = `HALF_MS_NS / `CLK_NS,
  parameter int SLOW_READ_MS = `SLOW_READ_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sched_sample,
  input wire logic pulse_pin,
  input wire logic level_pin,
  input wire logic quad_a_pin,
  input wire logic quad_b_pin,
  output logic measure_strobe,
  output logic binary_level_input
);
  localparam int DW = $clog2(HALF_MS_CYCLES);

  if (HALF_MS_CYCLES < 2 || SLOW_READ_MS < 1 || SLOW_READ_MS > 1023) begin : g_chk
    $error("digital_input_counter: parameter out of range");
  end

  typedef struct packed {
    logic [DW-1:0] div;
    logic half;
    logic phase;
    logic ms;
    logic [31:0] ticks;
    logic [31:0] acc;
    logic [31:0] total;
    logic [31:0] sample;
    logic [31:0] fixed;
    logic [31:0] quad;
    logic [31:0] seq;
    logic [31:0] rdata;
    logic [31:0] last_ms;
    logic [31:0] last_total;
    logic [31:0] base_ms;
    logic [31:0] base_total;
    logic [31:0] freq_cnt;
    logic [31:0] freq_ms;
    logic [15:0] gate;
    logic [15:0] lfsr;
    logic [7:0] deb;
    logic clr;
    logic edge_p;
    logic edge_l;
    logic inv;
    logic test;
    logic rot;
    logic have_prev;
    logic fvalid;
    logic level;
    logic strobe;
    logic qa;
    logic qb;
    dic_pkg::freq_state_t fq;
    logic [9:0] wait_ms;
  } state_t;

  state_t q;
  state_t n;

  function automatic logic mapped(input logic [11:0] a);
    mapped = a[1:0] == 2'b00 && a <= `OFF_SYNTH;
  endfunction

  logic p_state;
  logic p_chg;
  logic l_state;
  logic l_chg;
  logic qa_s;
  logic qb_s;
  logic setup;
  logic done;
  logic wr;
  logic meas;
  logic rise;
  logic synth_rd;
  logic slow_rd;
  logic [31:0] elapsed;
  logic [31:0] quarter;
  logic [31:0] synth;

  // All four channels are synchronised in parallel every clock; only pulse and level are debounced
  input_debounce #(.W(8)) u_pulse (
    .pclk(pclk), .presetn(presetn), .raw(pulse_pin), .half_ms(q.half),
    .setting(q.deb), .state(p_state), .changed(p_chg)
  );
  input_debounce #(.W(8)) u_level (
    .pclk(pclk), .presetn(presetn), .raw(level_pin), .half_ms(q.half),
    .setting(q.deb), .state(l_state), .changed(l_chg)
  );
  input_debounce #(.W(8)) u_qa (
    .pclk(pclk), .presetn(presetn), .raw(quad_a_pin), .half_ms(q.half),
    .setting(8'h00), .state(qa_s), .changed()
  );
  input_debounce #(.W(8)) u_qb (
    .pclk(pclk), .presetn(presetn), .raw(quad_b_pin), .half_ms(q.half),
    .setting(8'h00), .state(qb_s), .changed()
  );

  assign setup = psel && !penable;
  assign done = psel && penable && pready;
  assign wr = done && pwrite;
  assign rise = p_chg && p_state;
  // Scheduled, edge-triggered and software measurements
  assign meas = sched_sample || (q.edge_p && p_chg) || (q.edge_l && l_chg)
    || (wr && paddr == `OFF_SAMPLE);
  assign elapsed = q.ticks - q.last_ms;
  assign quarter = {18'h0, q.gate[15:2]};
  assign synth_rd = !pwrite && paddr == `OFF_SYNTH && q.test;
  assign slow_rd = synth_rd && q.fixed == `CODE_INC_SLOW;

  always_comb begin
    synth = q.fixed;
    if (q.test) begin
      case (q.fixed)
        `CODE_TICK: synth = q.ticks;
        `CODE_RAND: synth = {16'h0, q.lfsr};
        `CODE_INC, `CODE_INC_SLOW: synth = q.seq;
        default: synth = q.fixed;
      endcase
    end
  end

  always_comb begin
    n = q;
    n.half = 1'b0;
    n.ms = 1'b0;
    // Half-ms enable, and ms tick on every second one
    if (q.div == DW'(HALF_MS_CYCLES - 1)) begin
      n.div = '0;
      n.half = 1'b1;
      n.phase = !q.phase;
      if (q.phase) begin
        n.ms = 1'b1;
        n.ticks = q.ticks + 32'h1;
      end
    end else begin
      n.div = DW'(q.div + 1'b1);
    end
    n.strobe = meas;
    n.total = q.total + {31'h0, rise};
    if (meas) begin
      n.sample = q.acc;
    end
    if (wr && paddr == `OFF_COUNT) begin
      n.acc = pwdata;
    end else if (meas && q.clr) begin
      n.acc = {31'h0, rise};
    end else begin
      n.acc = q.acc + {31'h0, rise};
    end
    if (meas) begin
      n.last_ms = q.ticks;
      n.last_total = q.total;
      n.have_prev = 1'b1;
      if (q.fq == dic_pkg::FQ_IDLE) begin
        // One pulse per gate is the least count, hence 1000/gate Hz
        if (q.have_prev && elapsed + quarter >= {16'h0, q.gate}
            && elapsed <= {16'h0, q.gate} + quarter) begin
          n.freq_cnt = q.total - q.last_total;
          n.freq_ms = elapsed;
          n.fvalid = 1'b1;
        end else begin
          n.fq = dic_pkg::FQ_SECOND;
          n.base_ms = q.ticks;
          n.base_total = q.total;
          n.fvalid = 1'b0;
        end
      end
    end
    if (q.fq == dic_pkg::FQ_SECOND && q.ticks - q.base_ms >= {16'h0, q.gate}) begin
      n.freq_cnt = q.total - q.base_total;
      n.freq_ms = q.ticks - q.base_ms;
      n.fvalid = 1'b1;
      n.fq = dic_pkg::FQ_IDLE;
    end
    n.level = l_state ^ q.inv;
    n.qa = qa_s;
    n.qb = qb_s;
    // Exactly one phase moved: one quarter step, every clock
    if ((qa_s ^ q.qa) ^ (qb_s ^ q.qb)) begin
      if (q.qa ^ qb_s ^ q.rot) begin
        n.quad = q.quad + 32'h1;
      end else begin
        n.quad = q.quad - 32'h1;
      end
    end
    if (q.wait_ms != 10'h0 && q.ms) begin
      n.wait_ms = q.wait_ms - 10'h1;
    end
    if (setup && !pwrite) begin
      case (paddr)
        `OFF_CTRL: n.rdata = {16'h0, q.deb, 2'b00, q.rot, q.test, q.inv, q.edge_l,
          q.edge_p, q.clr};
        `OFF_COUNT: n.rdata = q.acc;
        `OFF_SAMPLE: n.rdata = q.sample;
        `OFF_GATE: n.rdata = {16'h0, q.gate};
        `OFF_FREQ_CNT: n.rdata = q.freq_cnt;
        `OFF_FREQ_MS: n.rdata = q.freq_ms;
        `OFF_STATUS: n.rdata = {29'h0, q.fq == dic_pkg::FQ_SECOND, q.fvalid, q.level};
        `OFF_QUAD: n.rdata = q.quad;
        `OFF_FIXED: n.rdata = q.fixed;
        `OFF_SYNTH: n.rdata = synth;
        default: n.rdata = 32'h0;
      endcase
      if (slow_rd) begin
        n.wait_ms = 10'(SLOW_READ_MS);
      end
    end
    if (done && synth_rd) begin
      if (q.fixed == `CODE_INC || q.fixed == `CODE_INC_SLOW) begin
        n.seq = q.seq + 32'h1;
      end
      if (q.fixed == `CODE_RAND) begin
        n.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};
      end
    end
    if (wr) begin
      case (paddr)
        `OFF_CTRL: begin
          n.clr = pwdata[`CTRL_CLR];
          n.edge_p = pwdata[`CTRL_EDGE_P];
          n.edge_l = pwdata[`CTRL_EDGE_L];
          n.inv = pwdata[`CTRL_INV];
          n.test = pwdata[`CTRL_TEST];
          n.rot = pwdata[`CTRL_ROT];
          n.deb = pwdata[`CTRL_DEB_HI:`CTRL_DEB_LO];
        end
        `OFF_GATE: n.gate = pwdata[15:0];
        `OFF_QUAD: n.quad = pwdata;
        `OFF_FIXED: n.fixed = pwdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.gate <= `GATE_RST;
      q.lfsr <= `LFSR_SEED;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.wait_ms == 10'h0;
  assign pslverr = psel && penable && !mapped(paddr);
  assign measure_strobe = q.strobe;
  assign binary_level_input = q.level;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_acc_wrap: assert property ((q.acc == 32'hFFFF_FFFF && rise && !meas && !wr)
    |=> q.acc == 32'h0)
    else $error("accumulator did not wrap");
  chk_clear_sample: assert property ((meas && q.clr && !(wr && paddr == `OFF_COUNT))
    |=> q.acc == {31'h0, $past(rise)} && q.sample == $past(q.acc))
    else $error("clear on sample failed");
  chk_keep_total: assert property ((meas && !q.clr && !wr)
    |=> q.acc == $past(q.acc) + {31'h0, $past(rise)})
    else $error("running total lost at measurement");
  chk_cal_load: assert property ((wr && paddr == `OFF_COUNT) |=> q.acc == $past(pwdata))
    else $error("calibration load failed");
  chk_pulse_edge: assert property ((q.edge_p && p_chg) |=> measure_strobe)
    else $error("pulse change did not trigger measurement");
  chk_level_edge: assert property ((q.edge_l && l_chg) |=> measure_strobe)
    else $error("level change did not trigger measurement");
  chk_level_sense: assert property (1'b1
    |=> binary_level_input == ($past(l_state) ^ $past(q.inv)))
    else $error("level sense wrong");
  chk_second_read: assert property ((meas && q.fq == dic_pkg::FQ_IDLE && !q.have_prev)
    |=> q.fq == dic_pkg::FQ_SECOND && !q.fvalid)
    else $error("missing previous reading did not start two readings");
  chk_slow_hold: assert property ((setup && slow_rd) |=> !pready [*8])
    else $error("slow test read completed early");
  chk_inc_read: assert property ((done && synth_rd && q.fixed == `CODE_INC)
    |=> q.seq == $past(q.seq) + 32'h1)
    else $error("test value did not increment");

  cov_wrap: cover property (q.acc == 32'hFFFF_FFFF ##1 q.acc == 32'h0);
  cov_freq_direct: cover property (meas && q.have_prev ##1 q.fvalid);
  cov_second_done: cover property (q.fq == dic_pkg::FQ_SECOND ##1 q.fq == dic_pkg::FQ_IDLE);
  cov_slow_read: cover property (done && slow_rd);
endmodule // digital_input_counter

// >>> bench/sensor_model.sv
// Behavioural pulse switch, level switch and quadrature encoder
`timescale 1ns/1ps
module sensor_model (
  input wire logic pclk,
  output logic pulse_pin,
  output logic level_pin,
  output logic quad_a_pin,
  output logic quad_b_pin
);
  logic [1:0] phase;
  // Counter line has a pull-up, so it idles high
  initial begin
    pulse_pin = 1'b1;
    level_pin = 1'b0;
    quad_a_pin = 1'b0;
    quad_b_pin = 1'b0;
    phase = 2'b00;
  end
  task automatic pulses(input int n, input int lo, input int hi);
    repeat (n) begin
      @(posedge pclk);
      pulse_pin <= 1'b0;
      repeat (lo) @(posedge pclk);
      pulse_pin <= 1'b1;
      repeat (hi) @(posedge pclk);
    end
  endtask
  task automatic level(input logic v);
    @(posedge pclk);
    level_pin <= v;
  endtask
  // Gray sequence 00,01,11,10 when stepping up
  task automatic quad(input int n, input logic up);
    repeat (n) begin
      @(posedge pclk);
      phase = up ? phase + 2'd1 : phase - 2'd1;
      quad_a_pin <= phase[1];
      quad_b_pin <= phase[1] ^ phase[0];
      repeat (6) @(posedge pclk);
    end
  endtask
endmodule // sensor_model

// >>> bench/digital_input_counter_bench.sv
// Self-checking bench for the digital input counter
`timescale 1ns/1ps
`include "dic_regs.svh"
module digital_input_counter_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sched_sample = 1'b0;
  logic pulse_pin;
  logic level_pin;
  logic quad_a_pin;
  logic quad_b_pin;
  logic measure_strobe;
  logic binary_level_input;
  int mismatches = 0;
  int compares = 0;
  int strobes = 0;
  int waits;
  int n;
  int s0;
  logic [31:0] rd;
  logic [31:0] a;
  logic err;
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (measure_strobe === 1'b1) strobes <= strobes + 1;
  digital_input_counter #(.HALF_MS_CYCLES(4), .SLOW_READ_MS(2)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sched_sample(sched_sample), .pulse_pin(pulse_pin), .level_pin(level_pin),
    .quad_a_pin(quad_a_pin), .quad_b_pin(quad_b_pin), .measure_strobe(measure_strobe),
    .binary_level_input(binary_level_input));
  sensor_model sensors (.pclk(pclk), .pulse_pin(pulse_pin), .level_pin(level_pin),
    .quad_a_pin(quad_a_pin), .quad_b_pin(quad_b_pin));
  function automatic logic [31:0] pos_exp(input int steps, input logic up, input logic rot);
    return (up ^ rot) ? steps : -steps;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer; waits counts access edges up to the one that samples pready high
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    waits = 0;
    do begin
      @(posedge pclk);
      waits++;
    end while (pready !== 1'b1 || penable !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic sample;
    @(posedge pclk);
    sched_sample <= 1'b1;
    @(posedge pclk);
    sched_sample <= 1'b0;
    @(negedge pclk);
    chk({31'h0, measure_strobe}, 32'h1, "strobe");
  endtask
  task automatic finish_test;
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #600000;
    mismatches++;
    finish_test;
  end
  initial begin
    void'($urandom(32'he46d3d18));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `OFF_CTRL, 0);
    chk(rd, 32'h0, "ctrl reset");
    apb(0, `OFF_GATE, 0);
    chk(rd, 32'h0000_00C8, "gate reset");
    apb(0, 12'h0FC, 0);
    chk({31'h0, err}, 32'h1, "unmapped");
    a = 32'hFFFF_FFFF - $urandom_range(3, 0);
    n = $urandom_range(8, 4);
    apb(1, `OFF_COUNT, a);
    sensors.pulses(n, 3, 3);
    repeat (6) @(posedge pclk);
    apb(0, `OFF_COUNT, 0);
    chk(rd, a + n, "wrap count");
    sample();
    apb(0, `OFF_SAMPLE, 0);
    chk(rd, a + n, "sample");
    apb(0, `OFF_COUNT, 0);
    chk(rd, a + n, "running total");
    apb(1, `OFF_CTRL, 32'h0000_0001);
    sample();
    apb(0, `OFF_COUNT, 0);
    chk(rd, 32'h0, "clear on sample");
    apb(1, `OFF_CTRL, 32'h0000_0002);
    s0 = strobes;
    sensors.pulses(1, 4, 8);
    chk(strobes - s0, 2, "pulse edge samples");
    apb(1, `OFF_CTRL, 32'h0000_0004);
    s0 = strobes;
    sensors.level(1'b1);
    repeat (8) @(posedge pclk);
    chk({31'h0, binary_level_input}, 32'h1, "level high");
    sensors.level(1'b0);
    repeat (8) @(posedge pclk);
    chk({31'h0, binary_level_input}, 32'h0, "level low");
    chk(strobes - s0, 2, "level edge samples");
    apb(1, `OFF_CTRL, 32'h0000_0008);
    repeat (3) @(posedge pclk);
    chk({31'h0, binary_level_input}, 32'h1, "inverted low");
    sensors.level(1'b1);
    repeat (8) @(posedge pclk);
    chk({31'h0, binary_level_input}, 32'h0, "inverted high");
    apb(1, `OFF_CTRL, 32'h0000_0200);
    apb(1, `OFF_COUNT, 32'h0);
    sensors.pulses(1, 3, 30);
    sensors.pulses(1, 40, 40);
    apb(0, `OFF_COUNT, 0);
    chk(rd, 32'h1, "debounced count");
    apb(1, `OFF_CTRL, 32'h0);
    apb(1, `OFF_GATE, 32'h0000_0004);
    repeat (80) @(posedge pclk);
    sample();
    apb(0, `OFF_STATUS, 0);
    chk(rd, 32'h0000_0005, "second reading pending");
    repeat (27) @(posedge pclk);
    sample();
    n = $urandom_range(4, 1);
    sensors.pulses(n, 2, 2);
    repeat (30 - 5 * n) @(posedge pclk);
    sample();
    apb(0, `OFF_FREQ_CNT, 0);
    chk(rd, n, "frequency count");
    apb(0, `OFF_FREQ_MS, 0);
    chk(rd, 32'h0000_0004, "frequency window");
    apb(1, `OFF_QUAD, 32'h0);
    n = $urandom_range(12, 4);
    sensors.quad(n, 1'b1);
    apb(0, `OFF_QUAD, 0);
    chk(rd, pos_exp(n, 1'b1, 1'b0), "quad up");
    apb(1, `OFF_CTRL, 32'h0000_0020);
    apb(1, `OFF_QUAD, 32'h0);
    sensors.quad(3, 1'b1);
    apb(0, `OFF_QUAD, 0);
    chk(rd, pos_exp(3, 1'b1, 1'b1), "quad reversed");
    a = $urandom;
    apb(1, `OFF_CTRL, 32'h0);
    apb(1, `OFF_FIXED, a);
    apb(0, `OFF_SYNTH, 0);
    chk(rd, a, "fixed value");
    apb(1, `OFF_CTRL, 32'h0000_0010);
    apb(1, `OFF_FIXED, `CODE_INC);
    apb(0, `OFF_SYNTH, 0);
    a = rd;
    apb(0, `OFF_SYNTH, 0);
    chk(rd, a + 1, "increment");
    apb(1, `OFF_FIXED, `CODE_RAND);
    apb(0, `OFF_SYNTH, 0);
    a = rd;
    apb(0, `OFF_SYNTH, 0);
    chk({31'h0, rd != a && rd[31:16] == 16'h0}, 32'h1, "random advances");
    apb(1, `OFF_FIXED, `CODE_INC_SLOW);
    apb(0, `OFF_SYNTH, 0);
    a = rd;
    apb(0, `OFF_SYNTH, 0);
    chk(rd, a + 1, "slow increment");
    chk({31'h0, waits >= 8}, 32'h1, "slow read wait");
    apb(1, `OFF_FIXED, `CODE_TICK);
    apb(0, `OFF_SYNTH, 0);
    a = rd;
    repeat (40) @(posedge pclk);
    apb(0, `OFF_SYNTH, 0);
    chk({31'h0, rd > a}, 32'h1, "tick advances");
    finish_test;
  end
endmodule // digital_input_counter_bench
